//--- src/cso_ocp_fault.sv
// Purpose: Overcurrent trip, fault counting, clearing, PWM truncation, gain select
// Assumes: Shunt samples arrive on sys_clk; PWM and gain code inputs are pins
// Notes:   Gate outputs are registered, so cuts land one cycle after the trip
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module cso_ocp_fault #(
	parameter int SAMPLE_W = 10
) (
	// Clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	// Register port
	input  wire logic [cso_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [31:0]                 reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [31:0]                 reg_rdata,
	// Sense front end, signed shunt voltage per phase
	input  wire logic [2:0][SAMPLE_W-1:0]    shunt_sample,
	// PWM pins and recirculation state
	input  wire logic [2:0]                  pwm_high_in,
	input  wire logic [2:0]                  pwm_low_in,
	input  wire logic                        recirc_low_side,
	// Gain resistor measurement code from the gain pin
	input  wire logic [2:0]                  gain_resistor_pin,
	// Gate drive, fault and gain in effect
	output logic      [2:0]                  high_gate_drive,
	output logic      [2:0]                  low_gate_drive,
	output logic                             fault_out_n,
	output logic      [2:0]                  gain_in_effect
);
	import cso_pkg::*;

	typedef struct packed {
		logic [2:0]      hi_s1;
		logic [2:0]      hi_s2;
		logic [2:0]      hi_d;
		logic [2:0]      lo_s1;
		logic [2:0]      lo_s2;
		logic [2:0]      rcode_s1;
		logic [2:0]      rcode_s2;
		logic [2:0]      high_gate;
		logic [2:0]      low_gate;
		logic [7:0]      pos_lvl;
		logic [7:0]      neg_lvl;
		logic [1:0]      deg_sel;
		logic            trunc_dis;
		logic            latch;
		cso_target_t     target;
		logic            ocp_dis;
		logic            alt_recirc;
		logic [2:0]      blank_sel;
		logic [2:0]      gain_code;
		logic            gain_ana;
		logic [2:0]      gain_cap;
		logic [2:0]      gain_eff;
		logic [7:0]      start_cnt;
		logic            start_done;
		logic [7:0]      blank_cnt;
		logic [2:0][6:0] deg_cnt;
		logic [2:0]      seen;
		logic [2:0][4:0] cnt;
		logic [2:0][1:0] idle;
		logic            trunc;
		logic            cyc_clean;
		logic            period_ok;
		logic            fault;
		logic            fault_seen;
		logic [31:0]     rdata;
	} cso_state_t;

	cso_state_t s_reg;
	cso_state_t s_next;

	logic [2:0] raw;
	logic [2:0] deg_hit;
	logic [2:0] ev;
	logic [2:0] inc;
	logic [2:0] hi_rise;
	logic       blank;
	logic       trunc_en;
	logic       trunc_hit;
	logic       trunc_now;
	logic       fault_set;
	logic       clr_req;
	logic       clr_ok;
	logic [4:0] tgt_count;
	logic [2:0] gain_sel;

	always_comb begin
		s_next = s_reg;
		raw = '0;
		deg_hit = '0;
		ev = '0;
		inc = '0;
		fault_set = 1'b0;
		// Pin synchronisers
		s_next.hi_s1 = pwm_high_in;
		s_next.hi_s2 = s_reg.hi_s1;
		s_next.hi_d = s_reg.hi_s2;
		s_next.lo_s1 = pwm_low_in;
		s_next.lo_s2 = s_reg.lo_s1;
		s_next.rcode_s1 = gain_resistor_pin;
		s_next.rcode_s2 = s_reg.rcode_s1;
		hi_rise = s_reg.hi_s2 & ~s_reg.hi_d;
		// Blanking restarts on any high gate edge of any phase
		// The edge cycle itself is blanked, else a switching spike slips through
		blank = (s_reg.blank_cnt != 8'h00) || (|(s_reg.hi_s2 ^ s_reg.hi_d));
		if (|(s_reg.hi_s2 ^ s_reg.hi_d)) begin
			s_next.blank_cnt = 8'((4'(s_reg.blank_sel) + 4'h1) * BLANK_STEP_CYC);
		end else if (blank) begin
			s_next.blank_cnt = s_reg.blank_cnt - 8'h01;
		end
		trunc_en = !s_reg.trunc_dis && !s_reg.ocp_dis;
		trunc_hit = trunc_en && (|raw_any()) && !blank;
		for (int i = 0; i < 3; i++) begin
			// Shunt-referred levels, no gain term involved
			raw[i] = !s_reg.ocp_dis &&
				(($signed(shunt_sample[i]) > $signed({2'b00, s_reg.pos_lvl})) ||
				 ($signed(shunt_sample[i]) < -$signed({2'b00, s_reg.neg_lvl})));
			if (raw[i]) begin
				if (s_reg.deg_cnt[i] < DEG_CYC[s_reg.deg_sel]) begin
					s_next.deg_cnt[i] = s_reg.deg_cnt[i] + 7'h01;
				end
			end else begin
				s_next.deg_cnt[i] = 7'h00;
			end
			deg_hit[i] = raw[i] && (s_reg.deg_cnt[i] >= DEG_CYC[s_reg.deg_sel]);
			// Truncation takes the raw path, so the fault marks a truncation
			ev[i] = trunc_en ? (raw[i] && !blank) : deg_hit[i];
			// One event per phase per cycle
			if (hi_rise[i]) begin
				s_next.seen[i] = ev[i];
				s_next.idle[i] = 2'h0;
				if (!s_reg.seen[i]) begin
					if (s_reg.idle[i] == IDLE_LIMIT - 2'h1) begin
						s_next.cnt[i] = 5'h00;
					end else begin
						s_next.idle[i] = s_reg.idle[i] + 2'h1;
					end
				end
				inc[i] = ev[i];
			end else if (ev[i] && !s_reg.seen[i]) begin
				s_next.seen[i] = 1'b1;
				s_next.idle[i] = 2'h0;
				inc[i] = 1'b1;
			end
			// Saturates at target so later events keep re-asserting the fault
			if (inc[i] && s_next.cnt[i] < tgt_count) begin
				s_next.cnt[i] = s_next.cnt[i] + 5'h01;
			end
			if (inc[i] && s_next.cnt[i] >= tgt_count &&
				(s_reg.target == TGT_8 || s_reg.target == TGT_16)) begin
				fault_set = 1'b1;
			end
		end
		if (s_reg.target == TGT_EVERY && |ev) begin
			fault_set = 1'b1;
		end
		// Truncation holds until the next PWM cycle starts; a new trip wins
		if (|hi_rise) begin
			s_next.trunc = 1'b0;
		end
		if (trunc_hit) begin
			s_next.trunc = 1'b1;
		end
		// A new cycle frees the gates on its first edge, not one cycle late
		trunc_now = s_next.trunc;
		if (s_reg.alt_recirc) begin
			s_next.high_gate = s_reg.hi_s2 & ~{3{trunc_now && recirc_low_side}};
			s_next.low_gate = s_reg.lo_s2 & ~{3{trunc_now && !recirc_low_side}};
		end else begin
			s_next.high_gate = s_reg.hi_s2 & ~{3{trunc_now}};
			s_next.low_gate = s_reg.lo_s2;
		end
		// Fault-free whole period tracking
		if (|ev) begin
			s_next.cyc_clean = 1'b0;
			s_next.period_ok = 1'b0;
		end else if (|hi_rise) begin
			s_next.period_ok = s_reg.period_ok || s_reg.cyc_clean;
			s_next.cyc_clean = 1'b1;
		end
		// Clear acceptance depends on latch and target mode
		clr_req = reg_wr && reg_addr == STATUS_OFS && reg_wdata[FAULT_BIT];
		if (!s_reg.latch) begin
			clr_ok = 1'b1;
		end else if (s_reg.target == TGT_8 || s_reg.target == TGT_16) begin
			clr_ok = s_reg.period_ok;
		end else begin
			clr_ok = !(|raw);
		end
		if (clr_req && clr_ok) begin
			s_next.fault = 1'b0;
		end
		if (fault_set) begin
			s_next.fault = 1'b1;
		end
		if (reg_wr && reg_addr == STATUS_OFS && reg_wdata[FAULT_SEEN_BIT]) begin
			s_next.fault_seen = 1'b0;
		end
		if (fault_set) begin
			s_next.fault_seen = 1'b1;
		end
		// Configuration writes take effect at once, in any state
		if (reg_wr && reg_addr == OCP_CFG_OFS) begin
			s_next.pos_lvl = reg_wdata[POS_LVL_LSB +: 8];
			s_next.neg_lvl = reg_wdata[NEG_LVL_LSB +: 8];
			s_next.deg_sel = reg_wdata[DEG_SEL_LSB +: 2];
			s_next.trunc_dis = reg_wdata[TRUNC_DIS_BIT];
			s_next.latch = reg_wdata[LATCH_BIT];
			s_next.target = cso_target_t'(reg_wdata[TARGET_LSB +: 2]);
			s_next.ocp_dis = reg_wdata[OCP_DIS_BIT];
			s_next.alt_recirc = reg_wdata[ALT_RECIRC_BIT];
			s_next.blank_sel = reg_wdata[BLANK_SEL_LSB +: 3];
		end
		if (reg_wr && reg_addr == GAIN_CFG_OFS) begin
			s_next.gain_code = reg_wdata[GAIN_CODE_LSB +: 3];
			s_next.gain_ana = reg_wdata[GAIN_ANA_BIT];
		end
		// Resistor code sampled once after start-up settles
		if (!s_reg.start_done) begin
			s_next.start_cnt = s_reg.start_cnt + 8'h01;
			if (s_reg.start_cnt == GAIN_MEAS_CYC - 8'h01) begin
				s_next.gain_cap = s_reg.rcode_s2;
				s_next.start_done = 1'b1;
			end
		end
		s_next.gain_eff = gain_sel;
		// Read data valid only in the cycle after the strobe
		s_next.rdata = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				OCP_CFG_OFS: begin
					s_next.rdata[POS_LVL_LSB +: 8] = s_reg.pos_lvl;
					s_next.rdata[NEG_LVL_LSB +: 8] = s_reg.neg_lvl;
					s_next.rdata[DEG_SEL_LSB +: 2] = s_reg.deg_sel;
					s_next.rdata[TRUNC_DIS_BIT] = s_reg.trunc_dis;
					s_next.rdata[LATCH_BIT] = s_reg.latch;
					s_next.rdata[TARGET_LSB +: 2] = s_reg.target;
					s_next.rdata[OCP_DIS_BIT] = s_reg.ocp_dis;
					s_next.rdata[ALT_RECIRC_BIT] = s_reg.alt_recirc;
					s_next.rdata[BLANK_SEL_LSB +: 3] = s_reg.blank_sel;
				end
				GAIN_CFG_OFS: begin
					s_next.rdata[GAIN_CODE_LSB +: 3] = s_reg.gain_code;
					s_next.rdata[GAIN_ANA_BIT] = s_reg.gain_ana;
				end
				STATUS_OFS: begin
					s_next.rdata[FAULT_BIT] = s_reg.fault;
					s_next.rdata[FAULT_SEEN_BIT] = s_reg.fault_seen;
					s_next.rdata[GAIN_ST_LSB +: 3] = gain_sel;
				end
				GAIN_VAL_OFS: begin
					s_next.rdata[6:0] = GAIN_TABLE[gain_sel];
				end
				default: begin
					s_next.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// Any phase trip, evaluated ahead of the per-phase loop
	function automatic logic [2:0] raw_any();
		logic [2:0] r;
		r = '0;
		for (int i = 0; i < 3; i++) begin
			r[i] = !s_reg.ocp_dis &&
				(($signed(shunt_sample[i]) > $signed({2'b00, s_reg.pos_lvl})) ||
				 ($signed(shunt_sample[i]) < -$signed({2'b00, s_reg.neg_lvl})));
		end
		return r;
	endfunction : raw_any

	always_comb begin
		unique case (s_reg.target)
			TGT_8:   tgt_count = TGT8_COUNT;
			TGT_16:  tgt_count = TGT16_COUNT;
			TGT_NONE, TGT_EVERY: tgt_count = TGT16_COUNT;
		endcase
		gain_sel = s_reg.gain_ana ? s_reg.gain_cap : s_reg.gain_code;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.pos_lvl <= POS_LVL_RST;
			s_reg.neg_lvl <= NEG_LVL_RST;
			s_reg.deg_sel <= DEG_SEL_RST;
			s_reg.trunc_dis <= TRUNC_DIS_RST;
			s_reg.latch <= LATCH_RST;
			s_reg.target <= TARGET_RST;
			s_reg.ocp_dis <= OCP_DIS_RST;
			s_reg.blank_sel <= BLANK_SEL_RST;
			s_reg.gain_code <= GAIN_CODE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata = s_reg.rdata;
	assign high_gate_drive = s_reg.high_gate;
	assign low_gate_drive = s_reg.low_gate;
	assign fault_out_n = !s_reg.fault;
	assign gain_in_effect = s_reg.gain_eff;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_trunc_cuts_high;
		(trunc_hit && !s_reg.alt_recirc) |=> (high_gate_drive == 3'b000);
	endproperty
	a_trunc_cuts_high: assert property (p_trunc_cuts_high)
		else $error("high gates not cut after trip");

	property p_low_untouched;
		!s_reg.alt_recirc |=> (low_gate_drive == $past(s_reg.lo_s2));
	endproperty
	a_low_untouched: assert property (p_low_untouched)
		else $error("low gate altered outside alternate recirculation");

	property p_blank_blocks;
		(blank && !s_reg.trunc && !(|hi_rise)) |=> !s_reg.trunc;
	endproperty
	a_blank_blocks: assert property (p_blank_blocks)
		else $error("truncation during blanking");

	property p_disabled_quiet;
		(s_reg.ocp_dis && !s_reg.fault && !s_reg.trunc) |=> (!s_reg.fault && !s_reg.trunc);
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet)
		else $error("trip acted while protection disabled");

	property p_every_sets;
		(s_reg.target == TGT_EVERY && |ev) |=> !fault_out_n;
	endproperty
	a_every_sets: assert property (p_every_sets)
		else $error("every-event mode did not raise fault");

	property p_seen_follows;
		$rose(s_reg.fault) |-> s_reg.fault_seen;
	endproperty
	a_seen_follows: assert property (p_seen_follows)
		else $error("fault not recorded in status");

	property p_idle_reset;
		(hi_rise[0] && !s_reg.seen[0] && s_reg.idle[0] == 2'h2 && !ev[0]) |=> (s_reg.cnt[0] == 5'h00);
	endproperty
	a_idle_reset: assert property (p_idle_reset)
		else $error("counter not reset after idle cycles");

	property p_unlatched_clear;
		(clr_req && !s_reg.latch && !fault_set) |=> !s_reg.fault;
	endproperty
	a_unlatched_clear: assert property (p_unlatched_clear)
		else $error("non-latched clear refused");

	property p_latched_hold;
		(clr_req && s_reg.latch && s_reg.target == TGT_EVERY && |raw && s_reg.fault) |=> s_reg.fault;
	endproperty
	a_latched_hold: assert property (p_latched_hold)
		else $error("latched fault cleared while trip present");
endmodule : cso_ocp_fault

//--- src/cso_pkg.sv
// Purpose: Shared constants and types for the current sense overcurrent block
// Assumes: 100 MHz system clock, register offsets are byte addresses
// Notes:   Deglitch, blanking and start-up timings are plain defaults
package cso_pkg;
	// Clock
	localparam int CLK_NS = 10;

	// Register map
	localparam int          ADDR_W      = 4;
	localparam logic [3:0]  OCP_CFG_OFS = 4'h0;
	localparam logic [3:0]  GAIN_CFG_OFS = 4'h4;
	localparam logic [3:0]  STATUS_OFS  = 4'h8;
	localparam logic [3:0]  GAIN_VAL_OFS = 4'hC;

	// Fields of the overcurrent configuration register
	localparam int POS_LVL_LSB   = 0;
	localparam int NEG_LVL_LSB   = 8;
	localparam int DEG_SEL_LSB   = 16;
	localparam int TRUNC_DIS_BIT = 18;
	localparam int LATCH_BIT     = 19;
	localparam int TARGET_LSB    = 20;
	localparam int OCP_DIS_BIT   = 22;
	localparam int ALT_RECIRC_BIT = 23;
	localparam int BLANK_SEL_LSB = 24;

	// Fields of the gain configuration and status registers
	localparam int GAIN_CODE_LSB  = 0;
	localparam int GAIN_ANA_BIT   = 3;
	localparam int FAULT_BIT      = 0;
	localparam int FAULT_SEEN_BIT = 1;
	localparam int GAIN_ST_LSB    = 4;

	// Reset values
	localparam logic [7:0] POS_LVL_RST   = 8'hFF;
	localparam logic [7:0] NEG_LVL_RST   = 8'hFF;
	localparam logic [1:0] DEG_SEL_RST   = 2'h0;
	localparam logic       TRUNC_DIS_RST = 1'b1;
	localparam logic       LATCH_RST     = 1'b1;
	localparam logic       OCP_DIS_RST   = 1'b0;
	localparam logic [2:0] BLANK_SEL_RST = 3'h0;
	localparam logic [2:0] GAIN_CODE_RST = 3'h0;

	// Fault target modes
	typedef enum logic [1:0] {
		TGT_NONE  = 2'b00,
		TGT_EVERY = 2'b01,
		TGT_8     = 2'b10,
		TGT_16    = 2'b11
	} cso_target_t;
	localparam cso_target_t TARGET_RST = TGT_EVERY;

	// Counts
	localparam logic [4:0] TGT8_COUNT  = 5'h08;
	localparam logic [4:0] TGT16_COUNT = 5'h10;
	localparam logic [1:0] IDLE_LIMIT  = 2'h3;

	// Timing: figures in ns, counts derived and rounded up
	localparam int DEG0_NS = 0;
	localparam int DEG1_NS = 200;
	localparam int DEG2_NS = 500;
	localparam int DEG3_NS = 1000;
	localparam logic [6:0] DEG_CYC [4] = '{
		7'((DEG0_NS + CLK_NS - 1) / CLK_NS),
		7'((DEG1_NS + CLK_NS - 1) / CLK_NS),
		7'((DEG2_NS + CLK_NS - 1) / CLK_NS),
		7'((DEG3_NS + CLK_NS - 1) / CLK_NS)};
	localparam int BLANK_STEP_NS = 100;
	localparam logic [7:0] BLANK_STEP_CYC = 8'((BLANK_STEP_NS + CLK_NS - 1) / CLK_NS);
	localparam int GAIN_MEAS_NS = 1000;
	localparam logic [7:0] GAIN_MEAS_CYC = 8'((GAIN_MEAS_NS + CLK_NS - 1) / CLK_NS);

	// Amplifier gain per code
	localparam logic [6:0] GAIN_TABLE [8] = '{
		7'h04, 7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h40};
endpackage : cso_pkg

//--- verif/cso_mcu_model.sv
// Purpose: Controller stand-in driving the PWM pins and watching the fault line
// Assumes: All three phases switch together, high side first in each period
// Notes:   Dead time keeps both sides of a leg off around every edge
`timescale 1ns/10ps
module cso_mcu_model #(
	parameter int PERIOD = 100,
	parameter int HIGH   = 60,
	parameter int DEAD   = 2
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Control and fault monitor
	input  wire logic       pwm_run,
	input  wire logic       fault_out_n,
	output logic      [7:0] fault_falls,
	// PWM pins
	output logic      [2:0] pwm_high_in,
	output logic      [2:0] pwm_low_in
);
	int   cnt;
	logic fault_d;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt         <= 0;
			fault_d     <= 1'b1;
			fault_falls <= 8'h00;
			pwm_high_in <= 3'h0;
			pwm_low_in  <= 3'h0;
		end else begin
			fault_d <= fault_out_n;
			if (fault_d && !fault_out_n) begin
				fault_falls <= fault_falls + 8'h01;
			end
			// One high rising edge per period, so each period is one cycle
			cnt         <= (!pwm_run || cnt == PERIOD - 1) ? 0 : cnt + 1;
			pwm_high_in <= (pwm_run && cnt < HIGH) ? 3'h7 : 3'h0;
			pwm_low_in  <= (pwm_run && cnt >= HIGH + DEAD && cnt < PERIOD - DEAD) ? 3'h7 : 3'h0;
		end
	end
endmodule : cso_mcu_model

//--- verif/cso_ocp_fault_tb.sv
// Purpose: Self-checking bench for overcurrent fault and truncation logic
// Assumes: Controller model gives a 1 us PWM period on all phases
// Notes:   Each scenario resets first, since counters carry state
`timescale 1ns/10ps
`define CSO_CHECK(got, exp) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); \
	end \
end
module cso_ocp_fault_tb;
	import cso_pkg::*;
	logic            sys_clk;
	logic            rst;
	logic [3:0]      reg_addr;
	logic [31:0]     reg_wdata;
	logic            reg_wr;
	logic            reg_rd;
	logic [31:0]     reg_rdata;
	logic [2:0][9:0] shunt_sample;
	logic [2:0]      pwm_high_in;
	logic [2:0]      pwm_low_in;
	logic [2:0]      gain_resistor_pin;
	logic [2:0]      high_gate_drive;
	logic [2:0]      low_gate_drive;
	logic            fault_out_n;
	logic [2:0]      gain_in_effect;
	logic            pwm_run;
	logic            recirc_low_side;
	logic [7:0]      fault_falls;
	logic [31:0]     rd_val;
	int              num_errors;
	int              check_count;
	logic [6:0]      gain_tab [8] = '{7'h04, 7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h40};

	cso_ocp_fault #(.SAMPLE_W(10)) cso_ocp_fault_i (.sys_clk(sys_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .shunt_sample(shunt_sample), .pwm_high_in(pwm_high_in),
		.pwm_low_in(pwm_low_in), .recirc_low_side(recirc_low_side),
		.gain_resistor_pin(gain_resistor_pin),
		.high_gate_drive(high_gate_drive), .low_gate_drive(low_gate_drive),
		.fault_out_n(fault_out_n), .gain_in_effect(gain_in_effect));
	cso_mcu_model cso_mcu_model_i (.sys_clk(sys_clk), .rst(rst), .pwm_run(pwm_run),
		.fault_out_n(fault_out_n), .fault_falls(fault_falls), .pwm_high_in(pwm_high_in),
		.pwm_low_in(pwm_low_in));

	initial sys_clk = 1'b0;
	always #(CLK_NS / 2) sys_clk = ~sys_clk;

	task automatic complete_run();
		if (num_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : settle

	task automatic do_reset();
		@(posedge sys_clk);
		rst          <= 1'b1;
		pwm_run      <= 1'b0;
		shunt_sample <= '0;
		repeat (20) @(posedge sys_clk);
		rst     <= 1'b0;
		pwm_run <= 1'b1;
	endtask : do_reset

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask : reg_read

	// Bounded wait for a high-side rising edge of phase A
	task automatic wait_rise();
		int n;
		n = 0;
		while (n < 300 && pwm_high_in[0] !== 1'b0) begin
			@(posedge sys_clk);
			n++;
		end
		while (n < 300 && pwm_high_in[0] !== 1'b1) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 300) begin
			num_errors++;
			complete_run();
		end
	endtask : wait_rise

	task automatic set_cfg(input logic tdis, input logic lat, input logic [1:0] tgt,
		input logic odis, input logic [1:0] deg, input logic [7:0] pos);
		logic [31:0] w;
		w = {24'h000040, pos};
		w[DEG_SEL_LSB +: 2] = deg;
		w[TRUNC_DIS_BIT] = tdis;
		w[LATCH_BIT] = lat;
		w[TARGET_LSB +: 2] = tgt;
		w[OCP_DIS_BIT] = odis;
		reg_write(OCP_CFG_OFS, w);
	endtask : set_cfg

	// Trip one phase for n cycles, mid high period, outside blanking
	task automatic ocp_event(input int ph, input int n);
		wait_rise();
		repeat (15) @(posedge sys_clk);
		shunt_sample[ph] <= 10'h064;
		repeat (n) @(posedge sys_clk);
		shunt_sample[ph] <= 10'h000;
		settle(3);
	endtask : ocp_event

	task automatic trunc_case(input int ph, input logic [9:0] v, input int dly, input logic cut);
		wait_rise();
		repeat (dly) @(posedge sys_clk);
		shunt_sample[ph] <= v;
		repeat (2) @(posedge sys_clk);
		shunt_sample[ph] <= 10'h000;
		@(negedge sys_clk);
		`CSO_CHECK(high_gate_drive, cut ? 3'h0 : 3'h7);
		`CSO_CHECK(low_gate_drive, 3'h0);
		`CSO_CHECK(fault_out_n, !cut);
		reg_write(STATUS_OFS, 32'h0000_0001);
		wait_rise();
		settle(5);
		`CSO_CHECK(high_gate_drive, 3'h7);
		`CSO_CHECK(fault_out_n, 1'b1);
	endtask : trunc_case

	task automatic trunc_scenario();
		do_reset();
		reg_read(OCP_CFG_OFS, rd_val);
		`CSO_CHECK(rd_val, 32'h001C_FFFF);
		set_cfg(1'b0, 1'b0, TGT_EVERY, 1'b0, 2'h3, 8'h40);
		trunc_case(1, 10'h064, 20, 1'b1);
		trunc_case(2, 10'h39C, 20, 1'b1);
		trunc_case(0, 10'h064, 6, 1'b0);
		`CSO_CHECK(fault_falls, 8'h02);
		set_cfg(1'b0, 1'b0, TGT_EVERY, 1'b0, 2'h0, 8'h7F);
		trunc_case(0, 10'h064, 20, 1'b0);
		set_cfg(1'b0, 1'b0, TGT_EVERY, 1'b1, 2'h0, 8'h40);
		trunc_case(0, 10'h064, 20, 1'b0);
	endtask : trunc_scenario

	// Delay 75 lands in low-side conduction, past the falling-edge blanking
	task automatic recirc_case(input logic [31:0] cfg, input logic low_rc, input int dly,
		input logic [2:0] hi_exp, input logic [2:0] lo_exp);
		reg_write(OCP_CFG_OFS, cfg);
		recirc_low_side <= low_rc;
		wait_rise();
		repeat (dly) @(posedge sys_clk);
		shunt_sample[2] <= 10'h064;
		repeat (2) @(posedge sys_clk);
		shunt_sample[2] <= 10'h000;
		@(negedge sys_clk);
		`CSO_CHECK(high_gate_drive, hi_exp);
		`CSO_CHECK(low_gate_drive, lo_exp);
		wait_rise();
		settle(5);
		`CSO_CHECK(high_gate_drive, 3'h7);
	endtask : recirc_case

	task automatic recirc_scenario();
		do_reset();
		recirc_case(32'h0090_4040, 1'b0, 75, 3'h0, 3'h0);
		recirc_case(32'h0090_4040, 1'b0, 20, 3'h7, 3'h0);
		recirc_case(32'h0090_4040, 1'b1, 20, 3'h0, 3'h0);
		recirc_case(32'h0090_4040, 1'b1, 75, 3'h0, 3'h7);
		recirc_case(32'h0010_4040, 1'b0, 75, 3'h0, 3'h7);
	endtask : recirc_scenario

	// Fault expected from event nf on; alt spreads events over two phases
	task automatic count_case(input logic [1:0] tgt, input int nf, input int nev,
		input logic alt, input int gap);
		do_reset();
		set_cfg(1'b1, 1'b0, tgt, 1'b0, 2'h0, 8'h40);
		for (int i = 1; i <= nev; i++) begin
			if (i == gap) begin
				repeat (3) wait_rise();
			end
			ocp_event(alt ? (i - 1) % 2 : 0, 4);
			`CSO_CHECK(fault_out_n, (nf != 0 && i >= nf) ? 1'b0 : 1'b1);
		end
	endtask : count_case

	task automatic clear_count(input logic lat);
		do_reset();
		set_cfg(1'b1, lat, TGT_8, 1'b0, 2'h0, 8'h40);
		repeat (8) ocp_event(0, 4);
		`CSO_CHECK(fault_out_n, 1'b0);
		reg_write(STATUS_OFS, 32'h0000_0001);
		settle(2);
		`CSO_CHECK(fault_out_n, !lat);
		repeat (2) wait_rise();
		// Pin edge needs the synchroniser delay before the clean period counts
		settle(4);
		reg_write(STATUS_OFS, 32'h0000_0001);
		settle(2);
		`CSO_CHECK(fault_out_n, 1'b1);
		reg_read(STATUS_OFS, rd_val);
		`CSO_CHECK(rd_val[FAULT_SEEN_BIT], 1'b1);
	endtask : clear_count

	task automatic clear_every(input logic lat);
		do_reset();
		set_cfg(1'b1, lat, TGT_EVERY, 1'b0, 2'h0, 8'h40);
		shunt_sample[0] <= 10'h064;
		settle(20);
		`CSO_CHECK(fault_out_n, 1'b0);
		reg_write(STATUS_OFS, 32'h0000_0001);
		settle(3);
		`CSO_CHECK(fault_out_n, 1'b0);
		shunt_sample[0] <= 10'h000;
		settle(5);
		reg_write(STATUS_OFS, 32'h0000_0001);
		settle(2);
		`CSO_CHECK(fault_out_n, 1'b1);
		reg_read(STATUS_OFS, rd_val);
		`CSO_CHECK(rd_val[FAULT_SEEN_BIT], 1'b1);
	endtask : clear_every

	task automatic deglitch_scenario();
		do_reset();
		set_cfg(1'b1, 1'b0, TGT_EVERY, 1'b0, 2'h1, 8'h40);
		ocp_event(0, 10);
		`CSO_CHECK(fault_out_n, 1'b1);
		ocp_event(0, 40);
		`CSO_CHECK(fault_out_n, 1'b0);
	endtask : deglitch_scenario

	task automatic gain_scenario();
		do_reset();
		repeat (110) @(posedge sys_clk);
		for (int c = 0; c < 8; c++) begin
			reg_write(GAIN_CFG_OFS, 32'(c));
			reg_read(GAIN_VAL_OFS, rd_val);
			`CSO_CHECK(rd_val, {25'h0, gain_tab[c]});
			`CSO_CHECK(gain_in_effect, 3'(c));
		end
		reg_write(GAIN_CFG_OFS, 32'h0000_0008);
		gain_resistor_pin <= 3'h2;
		reg_read(STATUS_OFS, rd_val);
		`CSO_CHECK(rd_val[6:4], 3'h5);
		reg_read(GAIN_VAL_OFS, rd_val);
		`CSO_CHECK(rd_val, 32'h0000_0018);
		`CSO_CHECK(gain_in_effect, 3'h5);
		reg_read(4'h2, rd_val);
		`CSO_CHECK(rd_val, 32'h0);
	endtask : gain_scenario

	initial begin
		repeat (100000) @(posedge sys_clk);
		num_errors++;
		complete_run();
	end

	initial begin
		num_errors = 0;
		check_count = 0;
		rst = 1'b1;
		pwm_run = 1'b0;
		recirc_low_side = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		shunt_sample = '0;
		gain_resistor_pin = 3'h5;
		do_reset();
		trunc_scenario();
		recirc_scenario();
		count_case(TGT_NONE, 0, 3, 1'b0, 0);
		count_case(TGT_EVERY, 1, 2, 1'b0, 0);
		count_case(TGT_16, 16, 16, 1'b0, 0);
		count_case(TGT_8, 15, 15, 1'b1, 0);
		count_case(TGT_8, 15, 15, 1'b0, 8);
		clear_count(1'b1);
		clear_count(1'b0);
		clear_every(1'b1);
		clear_every(1'b0);
		deglitch_scenario();
		gain_scenario();
		complete_run();
	end
endmodule : cso_ocp_fault_tb
